/* File: rtl/asc_pkg.sv */
package asc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  localparam int NUM_PINS = 14;
  localparam int PIN_LO_W = 8;
  localparam int PIN_HI_W = 6;
  localparam int PIN_NC = 9;
  localparam int CHAN_W = 4;
  localparam int DIV_W = 3;
  localparam int DIV_CNT_W = 6;
  localparam int TCNT_W = 4;
  localparam int CONV_TICKS = 16;
  localparam int SAR_FIRST = 1;
  localparam int CYC_W = 11;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PIN_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INTC = 8'h18;

  localparam int B_START = 7;
  localparam int B_BUSY = 6;
  localparam int B_POFF = 5;
  localparam int B_ALIGN = 4;
  localparam int B_IREF = 7;
  localparam int B_BGEN = 6;
  localparam int B_REFERENCE_SOURCE_SELECT = 4;
  localparam int B_GIE = 0;
  localparam int B_CIE = 1;
  localparam int B_FLAG = 2;

  localparam logic [CHAN_W-1:0] RST_CHAN = 4'h0;
  localparam logic [DIV_W-1:0] RST_DIV = 3'h0;
  localparam logic [PIN_LO_W-1:0] RST_PIN_LO = 8'hFF;
  localparam logic [PIN_HI_W-1:0] RST_PIN_HI = 6'h3F;
  localparam logic [DIV_W-1:0] DIV_UNDEF = 3'h7;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h6;
  localparam logic [DIV_W-1:0] DIV_SEL_2 = 3'h1;
  localparam logic [RES_W-1:0] SAR_INIT = 12'h800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_CONV} asc_state_type;

  typedef struct packed {
    logic [NUM_PINS-1:0] analog_sel;
    logic [NUM_PINS-1:0] pullup_off;
    logic [NUM_PINS-1:0] dir_override;
  } asc_pin_ctl_type;

  typedef struct packed {
    logic power_on;
    logic conv_reset;
    logic sample;
    logic [RES_W-1:0] dac_code;
    logic [CHAN_W-1:0] input_channel_select;
    logic internal_reference_channel_select;
    logic bandgap_enable;
    logic reference_source_select;
  } asc_core_ctl_type;

endpackage

/* File: rtl/asc_adck_div.sv */
`timescale 1ns/100ps
module asc_adck_div #(
  parameter int CNT_W = asc_pkg::DIV_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [asc_pkg::DIV_W-1:0] div_sel,
  output logic tick
);
  import asc_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] mask;
  logic [DIV_W-1:0] eff_sel;
  logic tick_ff;
  logic nxt_tick;

  // Undefined code runs as the slowest defined ratio
  always_comb begin
    eff_sel = (div_sel == DIV_UNDEF) ? DIV_LAST : div_sel;
    mask = CNT_W'({CNT_W{1'b1}} >> (CNT_W - int'(eff_sel)));
    nxt_tick = run && ((cnt_ff & mask) == mask);
    nxt_cnt = run ? cnt_ff + CNT_W'(1) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

/* File: rtl/asc_top.sv */
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module asc_top #(
  parameter bit PIN9_BONDED = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [asc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [asc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_in,
  input wire logic int_ack,
  output asc_pkg::asc_core_ctl_type core_ctl,
  output asc_pkg::asc_pin_ctl_type pin_ctl,
  output logic vref_pin_claim,
  output logic int_req
);
  import asc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic start_ff, nxt_start, busy_ff, nxt_busy, poff_ff, nxt_poff, align_ff, nxt_align;
  logic [CHAN_W-1:0] chan_ff, nxt_chan;
  logic iref_ff, nxt_iref, bgen_ff, nxt_bgen, reference_source_select_ff, nxt_reference_source_select;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic [PIN_LO_W-1:0] pin_lo_ff, nxt_pin_lo;
  logic [PIN_HI_W-1:0] pin_hi_ff, nxt_pin_hi;
  logic gie_ff, nxt_gie, cie_ff, nxt_cie, flag_ff, nxt_flag;
  asc_state_type state_ff, nxt_state;
  logic [TCNT_W-1:0] tcnt_ff, nxt_tcnt;
  logic [RES_W-1:0] sar_ff, nxt_sar, result_ff, nxt_result;
  logic cmp_meta_ff, cmp_sync_ff;
  asc_core_ctl_type core_ctl_ff, nxt_core_ctl;
  asc_pin_ctl_type pin_ctl_ff, nxt_pin_ctl;
  logic vref_claim_ff, int_req_ff;
  logic wr_en, ar_take, start_rise, start_fall, done, flag_clr, tick;
  logic [NUM_PINS-1:0] pin_en;
  int bi;

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    reg_known = (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_PIN_LO) ||
                (a == OFS_PIN_HI) || (a == OFS_RES_HI) || (a == OFS_RES_LO) ||
                (a == OFS_INTC);
  endfunction

  // Result byte for the chosen justification
  function automatic logic [7:0] res_byte(input logic [RES_W-1:0] r, input logic right,
                                          input logic hi);
    logic [15:0] w;
    w = right ? {4'h0, r} : {r, 4'h0};
    res_byte = hi ? w[15:8] : w[7:0];
  endfunction

  asc_adck_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_ff == ST_CONV),
    .div_sel(div_ff),
    .tick(tick)
  );

  // ****************************************
  // Bus, registers and sequencer
  // ****************************************
  always_comb begin
    bi = 0;
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    wr_en = aw_hold_ff && w_hold_ff && !bvalid_ff;
    if (wr_en) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = reg_known(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    ar_take = s_axi_arvalid && arready_ff;
    if (ar_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_rdata = '0;
      if (s_axi_araddr == OFS_CTRL0) begin
        nxt_rdata[B_START] = start_ff;
        nxt_rdata[B_BUSY] = busy_ff;
        nxt_rdata[B_POFF] = poff_ff;
        nxt_rdata[B_ALIGN] = align_ff;
        nxt_rdata[CHAN_W-1:0] = chan_ff;
      end else if (s_axi_araddr == OFS_CTRL1) begin
        nxt_rdata[B_IREF] = iref_ff;
        nxt_rdata[B_BGEN] = bgen_ff;
        nxt_rdata[B_REFERENCE_SOURCE_SELECT] = reference_source_select_ff;
        nxt_rdata[DIV_W-1:0] = div_ff;
      end else if (s_axi_araddr == OFS_PIN_LO) begin
        nxt_rdata[PIN_LO_W-1:0] = pin_lo_ff;
      end else if (s_axi_araddr == OFS_PIN_HI) begin
        nxt_rdata[PIN_HI_W-1:0] = pin_hi_ff;
      end else if (s_axi_araddr == OFS_RES_HI) begin
        nxt_rdata[7:0] = res_byte(result_ff, align_ff, 1'b1);
      end else if (s_axi_araddr == OFS_RES_LO) begin
        nxt_rdata[7:0] = res_byte(result_ff, align_ff, 1'b0);
      end else if (s_axi_araddr == OFS_INTC) begin
        nxt_rdata[B_GIE] = gie_ff;
        nxt_rdata[B_CIE] = cie_ff;
        nxt_rdata[B_FLAG] = flag_ff;
      end
    end
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready = !nxt_w_hold && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;

    nxt_start = start_ff;
    nxt_poff = poff_ff;
    nxt_align = align_ff;
    nxt_chan = chan_ff;
    nxt_iref = iref_ff;
    nxt_bgen = bgen_ff;
    nxt_reference_source_select = reference_source_select_ff;
    nxt_div = div_ff;
    nxt_pin_lo = pin_lo_ff;
    nxt_pin_hi = pin_hi_ff;
    nxt_gie = gie_ff;
    nxt_cie = cie_ff;
    flag_clr = 1'b0;
    if (wr_en && wstrb0_ff) begin
      if (awaddr_ff == OFS_CTRL0) begin
        nxt_start = wdata_ff[B_START];
        nxt_poff = wdata_ff[B_POFF];
        nxt_align = wdata_ff[B_ALIGN];
        nxt_chan = wdata_ff[CHAN_W-1:0];
      end else if (awaddr_ff == OFS_CTRL1) begin
        nxt_iref = wdata_ff[B_IREF];
        nxt_bgen = wdata_ff[B_BGEN];
        nxt_reference_source_select = wdata_ff[B_REFERENCE_SOURCE_SELECT];
        nxt_div = wdata_ff[DIV_W-1:0];
      end else if (awaddr_ff == OFS_PIN_LO) begin
        nxt_pin_lo = wdata_ff[PIN_LO_W-1:0];
      end else if (awaddr_ff == OFS_PIN_HI) begin
        nxt_pin_hi = wdata_ff[PIN_HI_W-1:0];
      end else if (awaddr_ff == OFS_INTC) begin
        nxt_gie = wdata_ff[B_GIE];
        nxt_cie = wdata_ff[B_CIE];
        flag_clr = !wdata_ff[B_FLAG];
      end
    end
    start_rise = !start_ff && nxt_start;
    start_fall = start_ff && !nxt_start;

    // Sequencer runs on its own after launch
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_tcnt = tcnt_ff;
    nxt_sar = sar_ff;
    nxt_result = result_ff;
    done = 1'b0;
    case (state_ff)
      ST_HOLD: begin
        if (start_fall) begin
          nxt_state = ST_CONV;
          nxt_tcnt = '0;
          nxt_sar = SAR_INIT;
        end
      end
      ST_CONV: begin
        if (poff_ff) begin
          nxt_state = ST_IDLE;
        end else if (tick) begin
          if (tcnt_ff >= TCNT_W'(SAR_FIRST) && tcnt_ff < TCNT_W'(SAR_FIRST + RES_W)) begin
            bi = RES_W - 1 - (int'(tcnt_ff) - SAR_FIRST);
            nxt_sar[bi] = cmp_sync_ff;
            if (bi > 0) begin
              nxt_sar[bi-1] = 1'b1;
            end
          end
          if (tcnt_ff == TCNT_W'(CONV_TICKS - 1)) begin
            done = 1'b1;
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
            nxt_result = sar_ff;
          end else begin
            nxt_tcnt = tcnt_ff + TCNT_W'(1);
          end
        end
      end
      default: begin
      end
    endcase
    if (start_rise) begin
      nxt_state = ST_HOLD;
      nxt_busy = 1'b1;
    end

    // Hardware set wins over clear
    nxt_flag = flag_ff && !flag_clr && !int_ack;
    if (done) begin
      nxt_flag = 1'b1;
    end

    pin_en = {pin_hi_ff, pin_lo_ff};
    pin_en[PIN_NC] = pin_en[PIN_NC] && PIN9_BONDED;
    nxt_pin_ctl.analog_sel = pin_en;
    nxt_pin_ctl.pullup_off = pin_en;
    nxt_pin_ctl.dir_override = pin_en;

    nxt_core_ctl.power_on = !poff_ff;
    nxt_core_ctl.conv_reset = (state_ff == ST_HOLD);
    nxt_core_ctl.sample = (state_ff == ST_CONV) && (tcnt_ff == '0);
    nxt_core_ctl.dac_code = sar_ff;
    nxt_core_ctl.input_channel_select = chan_ff;
    nxt_core_ctl.internal_reference_channel_select = iref_ff;
    nxt_core_ctl.bandgap_enable = bgen_ff;
    nxt_core_ctl.reference_source_select = reference_source_select_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
      start_ff <= 1'b0;
      busy_ff <= 1'b1;
      poff_ff <= 1'b1;
      align_ff <= 1'b0;
      chan_ff <= RST_CHAN;
      iref_ff <= 1'b0;
      bgen_ff <= 1'b0;
      reference_source_select_ff <= 1'b0;
      div_ff <= RST_DIV;
      pin_lo_ff <= RST_PIN_LO;
      pin_hi_ff <= RST_PIN_HI;
      gie_ff <= 1'b0;
      cie_ff <= 1'b0;
      flag_ff <= 1'b0;
      state_ff <= ST_IDLE;
      tcnt_ff <= '0;
      sar_ff <= '0;
      result_ff <= '0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
      core_ctl_ff <= '0;
      pin_ctl_ff <= '0;
      vref_claim_ff <= 1'b0;
      int_req_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      start_ff <= nxt_start;
      busy_ff <= nxt_busy;
      poff_ff <= nxt_poff;
      align_ff <= nxt_align;
      chan_ff <= nxt_chan;
      iref_ff <= nxt_iref;
      bgen_ff <= nxt_bgen;
      reference_source_select_ff <= nxt_reference_source_select;
      div_ff <= nxt_div;
      pin_lo_ff <= nxt_pin_lo;
      pin_hi_ff <= nxt_pin_hi;
      gie_ff <= nxt_gie;
      cie_ff <= nxt_cie;
      flag_ff <= nxt_flag;
      state_ff <= nxt_state;
      tcnt_ff <= nxt_tcnt;
      sar_ff <= nxt_sar;
      result_ff <= nxt_result;
      cmp_meta_ff <= cmp_in;
      cmp_sync_ff <= cmp_meta_ff;
      core_ctl_ff <= nxt_core_ctl;
      pin_ctl_ff <= nxt_pin_ctl;
      vref_claim_ff <= reference_source_select_ff;
      int_req_ff <= flag_ff && gie_ff && cie_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign core_ctl = core_ctl_ff;
  assign pin_ctl = pin_ctl_ff;
  assign vref_pin_claim = vref_claim_ff;
  assign int_req = int_req_ff;

  // ****************************************
  // Checks
  // ****************************************
  logic [CYC_W-1:0] conv_cyc_ff;
  logic div_chg_ff;
  logic [DIV_W-1:0] eff_div;

  assign eff_div = (div_ff == DIV_UNDEF) ? DIV_LAST : div_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_cyc_ff <= '0;
      div_chg_ff <= 1'b0;
    end else if (state_ff != ST_CONV) begin
      conv_cyc_ff <= '0;
      div_chg_ff <= 1'b0;
    end else begin
      conv_cyc_ff <= conv_cyc_ff + CYC_W'(1);
      div_chg_ff <= div_chg_ff || (nxt_div != div_ff);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_held_start;
    state_ff == ST_HOLD && start_ff;
  endsequence

  sequence s_released;
    !start_ff && !poff_ff;
  endsequence

  a_start_pulse_runs: assert property (s_held_start ##1 s_released |-> state_ff == ST_CONV)
    else $error("start pulse did not launch a conversion");
  a_start_high_busy: assert property ($rose(start_ff) |-> busy_ff ##1 core_ctl_ff.conv_reset)
    else $error("start high did not hold converter in reset with busy set");
  a_end_clears_busy: assert property (done |=> !busy_ff && flag_ff && state_ff == ST_IDLE)
    else $error("conversion end did not clear busy and set flag");
  a_irq_gating: assert property (flag_ff && gie_ff && cie_ff |=> int_req_ff)
    else $error("enabled request did not raise interrupt");
  a_irq_masked: assert property (!(gie_ff && cie_ff) |=> !int_req_ff)
    else $error("interrupt raised while not enabled");
  a_tick_div_two: assert property (div_ff == DIV_SEL_2 && $stable(div_ff) && tick && !done
      && state_ff == ST_CONV && !poff_ff && !start_rise |=> !tick ##1 tick)
    else $error("divide by two clock spacing wrong");
  a_conv_length: assert property (done && !div_chg_ff
      |-> conv_cyc_ff == CYC_W'(CONV_TICKS << eff_div))
    else $error("conversion length not sixteen converter clocks");
  a_power_off: assert property (poff_ff |=> !core_ctl_ff.power_on)
    else $error("converter powered while power-off set");
  a_vref_claim: assert property (reference_source_select_ff |=> vref_pin_claim ##0 core_ctl.reference_source_select)
    else $error("external reference not claimed");
  a_pin_enables: assert property (pin_hi_ff[PIN_HI_W-1] |=> pin_ctl_ff.analog_sel[NUM_PINS-1]
      && pin_ctl_ff.pullup_off[NUM_PINS-1] && pin_ctl_ff.dir_override[NUM_PINS-1])
    else $error("top upper enable bit not applied to its pin");
  a_pin_nine_open: assert property (!PIN9_BONDED |-> !pin_ctl_ff.analog_sel[PIN_NC])
    else $error("unbonded channel pin enabled");
  a_result_update: assert property (done |=> result_ff == $past(sar_ff))
    else $error("result not updated at conversion end");
  a_flag_holds: assert property (flag_ff && !flag_clr && !int_ack |=> flag_ff)
    else $error("request flag dropped without a clear");

endmodule

/* File: sim/adc_sequencer_control_tb.sv */
`timescale 1ns/100ps
module adc_sequencer_control_tb;
  import asc_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr, bv, bre, arv, arr, rv, rre;
  logic cmp_in, int_ack, vclaim, irq;
  logic [7:0] awa, ara, m_c0, m_c1, m_lo, m_hi, m_in;
  logic [31:0] wd, rd, got;
  logic [11:0] m_res;
  logic [3:0] ws;
  logic [1:0] br, rr, rsp;
  asc_core_ctl_type cc;
  asc_pin_ctl_type pc, pc_nc;
  int n_mismatch, compares, cyc, t0;

  asc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .cmp_in(cmp_in),
    .int_ack(int_ack), .core_ctl(cc), .pin_ctl(pc), .vref_pin_claim(vclaim), .int_req(irq));

  // Variant whose channel nine has no pin; shares every input
  asc_top #(.PIN9_BONDED(1'b0)) u_dut_nopin (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rre), .cmp_in(cmp_in), .int_ack(int_ack), .core_ctl(), .pin_ctl(pc_nc),
    .vref_pin_claim(), .int_req());

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  // ****************************************
  // Bus tasks and model
  // ****************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test;
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wd <= {24'h0, d};
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awv && awr) begin
        ta = 1;
        awv <= 1'b0;
      end
      if (wv && wr) begin
        tw = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bv);
    bre <= 1'b0;
    rsp = br;
    t0 = cyc;
    case (a)
      OFS_CTRL0: m_c0 = {d[7], d[7] | m_c0[6], d[5:0]};
      OFS_CTRL1: m_c1 = d & 8'hD7;
      OFS_PIN_LO: m_lo = d;
      OFS_PIN_HI: m_hi = d & 8'h3F;
      OFS_INTC: m_in = (d & 8'h03) | (m_in & d & 8'h04);
      default: ;
    endcase
  endtask

  task automatic rchk(input logic [7:0] a);
    logic [7:0] e;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    got = rd;
    rsp = rr;
    rre <= 1'b0;
    case (a)
      OFS_CTRL0: e = m_c0;
      OFS_CTRL1: e = m_c1;
      OFS_PIN_LO: e = m_lo;
      OFS_PIN_HI: e = m_hi;
      OFS_RES_HI: e = m_c0[4] ? {4'h0, m_res[11:8]} : m_res[11:4];
      OFS_RES_LO: e = m_c0[4] ? m_res[7:0] : {m_res[3:0], 4'h0};
      OFS_INTC: e = m_in;
      default: e = 8'h00;
    endcase
    chk(got, {24'h0, e});
  endtask

  task automatic conv(input int s);
    logic [7:0] c0;
    logic b;
    c0 = {3'b000, 1'($urandom), 4'($urandom)};
    b = 1'($urandom);
    cmp_in <= b;
    m_res = {12{b}};
    bw(OFS_CTRL1, {2'($urandom), 1'b0, 1'($urandom), 1'b0, 3'(s)});
    chk(rsp, RESP_OKAY);
    bw(OFS_INTC, 8'h03);
    bw(OFS_CTRL0, c0);
    repeat (20) @(posedge aclk);
    bw(OFS_CTRL0, c0 | 8'h80);
    repeat (2) @(posedge aclk);
    chk(cc.conv_reset, 1'b1);
    rchk(OFS_CTRL0);
    chk({cc.internal_reference_channel_select, cc.bandgap_enable}, m_c1[7:6]);
    chk({cc.reference_source_select, vclaim}, {2{m_c1[4]}});
    bw(OFS_CTRL0, c0);
    rchk(OFS_CTRL0);
    do @(posedge aclk); while (!irq);
    chk(cyc - t0, (16 << (s == 7 ? 6 : s)) + 2);
    chk(cc.dac_code, m_res);
    m_c0[6] = 1'b0;
    m_in[2] = 1'b1;
    rchk(OFS_CTRL0);
    rchk(OFS_RES_HI);
    rchk(OFS_RES_LO);
    rchk(OFS_INTC);
    chk(rsp, RESP_OKAY);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(17503));
    {aresetn, awv, wv, bre, arv, rre, cmp_in, int_ack} = '0;
    {awa, ara, wd, cyc, n_mismatch, compares, t0} = '0;
    ws = 4'hF;
    {m_c0, m_c1, m_lo, m_hi, m_in, m_res} = {8'h60, 8'h00, 8'hFF, 8'h3F, 8'h00, 12'h000};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int a = 0; a <= 8'h1C; a += 4) rchk(8'(a));
    chk(rsp, RESP_SLVERR);
    bw(8'h1C, 8'hFF);
    chk(rsp, RESP_SLVERR);
    repeat (3) begin
      bw(OFS_PIN_LO, 8'($urandom));
      bw(OFS_PIN_HI, 8'($urandom) | 8'h02);
      rchk(OFS_PIN_HI);
      chk(pc, {3{m_hi[5:0], m_lo}});
      chk(pc_nc, {3{m_hi[5:2], 1'b0, m_hi[0], m_lo}});
    end
    for (int i = 0; i < 16; i++) begin
      bw(OFS_CTRL0, 8'(i) | 8'((i & 1) << 5));
      repeat (2) @(posedge aclk);
      chk({cc.power_on, cc.input_channel_select}, {~m_c0[5], m_c0[3:0]});
    end
    for (int s = 0; s < 8; s++) conv(s);
    conv(6);
    bw(OFS_INTC, 8'h06);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    bw(OFS_INTC, 8'h07);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    int_ack <= 1'b1;
    @(posedge aclk);
    int_ack <= 1'b0;
    m_in[2] = 1'b0;
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rchk(OFS_INTC);
    bw(OFS_CTRL0, 8'h20);
    rchk(OFS_CTRL0);
    chk(cc.power_on, 1'b0);
    finish_test;
  end

  // Cuts a hang; run needs well under a fifth of this
  initial begin
    #400000;
    n_mismatch++;
    finish_test;
  end
endmodule
